// *** verilog/bat_regs.svh ***
/*
  Constants of the biphase audio transmit framer: cell positions, preamble
  line patterns, counter limits and reset values.
  Assumes inclusion by bare name from the package, the builder, the framer and the bench.
*/
`ifndef BAT_REGS_SVH
`define BAT_REGS_SVH

// subframe geometry, two line states per cell
`define BAT_CELLS 32
`define BAT_LAST_HALF 6'h3f
`define BAT_PRE_HALVES 6'h08

// cell positions inside a subframe
`define BAT_CELL_AUX_LO 4
`define BAT_CELL_AUX_HI 7
`define BAT_CELL_LSB24 4
`define BAT_CELL_LSB20 8
`define BAT_CELL_MSB 27
`define BAT_CELL_V 28
`define BAT_CELL_U 29
`define BAT_CELL_C 30
`define BAT_CELL_P 31

// source sample width
`define BAT_SAMPLE_W 24
`define BAT_FULL_BITS 5'h18

// preamble line states, first state in bit 7, prior level 0
`define BAT_PRE_BLOCK 8'he8
`define BAT_PRE_FIRST 8'he2
`define BAT_PRE_SECOND 8'he4

// channel-status block length in frames
`define BAT_FRAMES_PER_BLOCK 192
`define BAT_LAST_FRAME 8'hbf

// line level after reset and between frames
`define BAT_IDLE_LEVEL 1'b0

`endif

// *** verilog/bat_pkg.sv ***
/*
  Types of the biphase audio transmit framer: state enum, state struct and
  the parity helper.
  Assumes bat_regs.svh is reachable on the include path.
*/
`include "bat_regs.svh"

package bat_pkg;

  // gray codes along idle -> run -> underrun
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run = 2'b01,
    st_under = 2'b11
  } bat_state_e;

  typedef struct packed {
    bat_state_e st;
    logic [5:0] half;
    logic sub;
    logic [7:0] frame;
    logic line;
    logic oe;
    logic [31:0] cur_word;
    logic [31:0] nxt_word;
    logic take;
    logic under;
    logic blk;
  } bat_state_s;

  // even parity over cells 4..30, so cells 4..31 hold an even count of ones
  function automatic logic bat_even_parity(input logic [26:0] cells);
    bat_even_parity = ^cells;
  endfunction : bat_even_parity

endpackage : bat_pkg

// *** verilog/bat_subframe_build.sv ***
/*
  Combinational builder of the 32 payload cells of one subframe.
  Assumes an MSB-justified 24-bit sample; cells 0..3 stay zero and are
  replaced by the preamble in the framer.
*/
`timescale 1ns/10ps
`include "bat_regs.svh"

module bat_subframe_build import bat_pkg::*; (
  // sample and its format
  input wire logic [23:0] sample,
  input wire logic [4:0] src_bits,
  input wire logic word_24,
  input wire logic [3:0] aux,
  // side bits
  input wire logic validity,
  input wire logic user_bit,
  input wire logic chan_status,
  // built cells, index = cell number
  output logic [31:0] word
);

  logic [4:0] drop;
  logic [23:0] clean;

  // mask, place and protect the word
  always_comb begin
    drop = 5'h00;
    if (src_bits != 5'h00 && src_bits < `BAT_FULL_BITS) begin
      drop = `BAT_FULL_BITS - src_bits; // zero or oversize width means full
    end
    clean = sample & (24'hffffff << drop);
    word = 32'h0000_0000;
    if (word_24) begin
      word[`BAT_CELL_MSB:`BAT_CELL_LSB24] = clean;
    end else begin
      word[`BAT_CELL_MSB:`BAT_CELL_LSB20] = clean[23:4];
      word[`BAT_CELL_AUX_HI:`BAT_CELL_AUX_LO] = aux;
    end
    word[`BAT_CELL_V] = validity;
    word[`BAT_CELL_U] = user_bit;
    word[`BAT_CELL_C] = chan_status;
    word[`BAT_CELL_P] = bat_even_parity(word[30:4]);
  end

endmodule : bat_subframe_build

// *** verilog/bat_framer.sv ***
/*
  Biphase audio transmit framer: builds two subframes per frame with
  preambles and drives them biphase-mark coded on the serial data pin.
  Assumes clk_sys is the serial bit clock (128 times the frame rate), made
  inside the device, and that the sample source sits on the same clock.
*/
`timescale 1ns/10ps
`include "bat_regs.svh"

module bat_framer import bat_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control, same clock domain
  input wire logic digital_audio_transmit_mode,
  input wire logic word_24,
  input wire logic [4:0] src_bits,
  input wire logic mono,
  input wire logic mono_dup,
  // sample source, held until taken
  input wire logic sample_valid,
  input wire logic [23:0] left_sample,
  input wire logic [23:0] right_sample,
  input wire logic [3:0] left_aux,
  input wire logic [3:0] right_aux,
  input wire logic left_validity,
  input wire logic right_validity,
  input wire logic left_user,
  input wire logic right_user,
  input wire logic left_cs,
  input wire logic right_cs,
  // sample handshake
  output logic sample_take,
  // serial line
  output logic serial_data_pin,
  output logic serial_data_oe,
  // status pulses
  output logic underrun,
  output logic block_start
);

  bat_state_s r;
  bat_state_s next_r;
  logic [31:0] left_word;
  logic [31:0] right_word;
  logic [23:0] sec_sample;
  logic [3:0] sec_aux;
  logic sec_validity;
  logic [7:0] pre_code;
  logic data_bit;
  logic enable;

  assign enable = digital_audio_transmit_mode;

  // mono: second subframe repeats the first's sample, aux and validity or carries an invalid zero word
  always_comb begin
    sec_sample = right_sample;
    sec_aux = right_aux;
    sec_validity = right_validity;
    if (mono) begin
      sec_sample = mono_dup ? left_sample : 24'h000000;
      sec_aux = mono_dup ? left_aux : 4'h0;
      sec_validity = mono_dup ? left_validity : 1'b1;
    end
  end

  // one builder per subframe of the frame
  bat_subframe_build u_left (
    .sample(left_sample),
    .src_bits(src_bits),
    .word_24(word_24),
    .aux(left_aux),
    .validity(left_validity),
    .user_bit(left_user),
    .chan_status(left_cs),
    .word(left_word)
  );

  bat_subframe_build u_right (
    .sample(sec_sample),
    .src_bits(src_bits),
    .word_24(word_24),
    .aux(sec_aux),
    .validity(sec_validity),
    .user_bit(right_user),
    .chan_status(right_cs),
    .word(right_word)
  );

  // preamble choice for the subframe in flight
  always_comb begin
    if (r.sub) begin
      pre_code = `BAT_PRE_SECOND;
    end else if (r.frame == 8'h00) begin
      pre_code = `BAT_PRE_BLOCK;
    end else begin
      pre_code = `BAT_PRE_FIRST;
    end
  end

  // cell being coded; half[5:1] is the cell number
  assign data_bit = r.cur_word[r.half[5:1]];

  // next state: the whole framer lives in one struct
  always_comb begin
    next_r = r;
    next_r.take = 1'b0;
    next_r.under = 1'b0;
    next_r.blk = 1'b0;
    case (r.st)
      st_idle: begin
        next_r.line = `BAT_IDLE_LEVEL;
        next_r.oe = enable;
        next_r.frame = 8'h00;
        if (enable && sample_valid) begin
          next_r.st = st_run;
          next_r.half = 6'h00;
          next_r.sub = 1'b0;
          next_r.cur_word = left_word;
          next_r.nxt_word = right_word;
          next_r.take = 1'b1;
        end
      end
      st_run: begin
        next_r.oe = 1'b1;
        // preamble bypasses the coder, one line state per clock
        if (r.half < `BAT_PRE_HALVES) begin
          next_r.line = pre_code[3'h7 - r.half[2:0]];
        end else if (!r.half[0]) begin
          next_r.line = ~r.line;
        end else begin
          next_r.line = data_bit ? ~r.line : r.line;
        end
        if (r.half == 6'h00 && !r.sub && r.frame == 8'h00) begin
          next_r.blk = 1'b1;
        end
        next_r.half = r.half + 6'h01;
        if (r.half == `BAT_LAST_HALF) begin
          if (!r.sub) begin
            next_r.sub = 1'b1;
            next_r.cur_word = r.nxt_word;
          end else begin
            // frame boundary: the only point in st_run where a new sample is taken
            next_r.sub = 1'b0;
            next_r.frame = (r.frame == `BAT_LAST_FRAME) ? 8'h00 : r.frame + 8'h01;
            if (!enable) begin
              next_r.st = st_idle;
            end else if (sample_valid) begin
              next_r.cur_word = left_word;
              next_r.nxt_word = right_word;
              next_r.take = 1'b1;
            end else begin
              next_r.st = st_under;
              next_r.under = 1'b1;
            end
          end
        end
      end
      st_under: begin
        // parity leaves the line low anyway; forcing it guards a stale level
        next_r.line = `BAT_IDLE_LEVEL;
        next_r.oe = 1'b1;
        if (!enable) begin
          next_r.st = st_idle;
        end else if (sample_valid) begin
          next_r.st = st_run;
          next_r.half = 6'h00;
          next_r.cur_word = left_word;
          next_r.nxt_word = right_word;
          next_r.take = 1'b1;
        end
      end
      default: begin
        next_r.st = st_idle;
      end
    endcase
  end

  // single register bank, clk_sys is the internally made bit clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state flops
  assign serial_data_pin = r.line;
  assign serial_data_oe = r.oe;
  assign sample_take = r.take;
  assign underrun = r.under;
  assign block_start = r.blk;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  property p_sub_wrap;
    (r.st == st_run && r.half == `BAT_LAST_HALF && r.sub && enable && sample_valid) |=>
      (r.half == 6'h00 && !r.sub);
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("frame did not wrap after 128 clocks");

  property p_level_before_pre;
    (r.st == st_run && r.half == 6'h00) |-> !serial_data_pin;
  endproperty
  a_level_before_pre: assert property (p_level_before_pre) else $error("line not low before preamble");

  property p_pre_block;
    (r.st == st_run && r.half == 6'h00 && !r.sub && r.frame == 8'h00) |=>
      serial_data_pin ##1 serial_data_pin ##1 serial_data_pin ##1 !serial_data_pin ##1
      serial_data_pin ##1 !serial_data_pin [*3];
  endproperty
  a_pre_block: assert property (p_pre_block) else $error("block preamble pattern wrong");

  property p_pre_first;
    (r.st == st_run && r.half == 6'h00 && !r.sub && r.frame != 8'h00) |=>
      serial_data_pin ##1 serial_data_pin ##1 serial_data_pin ##1 !serial_data_pin [*3] ##1
      serial_data_pin ##1 !serial_data_pin;
  endproperty
  a_pre_first: assert property (p_pre_first) else $error("first subframe preamble wrong");

  property p_pre_second;
    (r.st == st_run && r.half == 6'h00 && r.sub) |=>
      serial_data_pin ##1 serial_data_pin ##1 serial_data_pin ##1 !serial_data_pin [*2] ##1
      serial_data_pin ##1 !serial_data_pin [*2];
  endproperty
  a_pre_second: assert property (p_pre_second) else $error("second subframe preamble wrong");

  property p_cell_edge;
    (r.st == st_run && r.half >= `BAT_PRE_HALVES && !r.half[0]) |=>
      (serial_data_pin != $past(serial_data_pin));
  endproperty
  a_cell_edge: assert property (p_cell_edge) else $error("no transition at cell start");

  property p_cell_data;
    (r.st == st_run && r.half > `BAT_PRE_HALVES && r.half[0]) |=>
      ((serial_data_pin != $past(serial_data_pin)) == $past(data_bit));
  endproperty
  a_cell_data: assert property (p_cell_data) else $error("mid-cell transition disagrees with bit");

  property p_end_low;
    (r.st == st_run && r.half == `BAT_LAST_HALF) |=> !serial_data_pin;
  endproperty
  a_end_low: assert property (p_end_low) else $error("odd parity left line high");

  property p_under_low;
    (r.st == st_under) |=> !serial_data_pin;
  endproperty
  a_under_low: assert property (p_under_low) else $error("line not restored after underrun");

  property p_frame_range;
    r.frame <= `BAT_LAST_FRAME;
  endproperty
  a_frame_range: assert property (p_frame_range) else $error("frame counter beyond block");

  property p_mono_invalid;
    (mono && !mono_dup) |-> right_word[`BAT_CELL_V];
  endproperty
  a_mono_invalid: assert property (p_mono_invalid) else $error("undup mono second subframe valid");

  property p_msb_place;
    (word_24 && src_bits == `BAT_FULL_BITS) |-> (left_word[27:4] == left_sample);
  endproperty
  a_msb_place: assert property (p_msb_place) else $error("24-bit sample misplaced");

  property p_block_pulse;
    block_start |-> (r.st == st_run && r.half == 6'h01 && !r.sub && r.frame == 8'h00 && serial_data_pin);
  endproperty
  a_block_pulse: assert property (p_block_pulse) else $error("block pulse off the block preamble");

  property p_frame_wrap;
    (r.st == st_run && r.half == `BAT_LAST_HALF && r.sub && r.frame == `BAT_LAST_FRAME) |=> (r.frame == 8'h00);
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not wrap after block");

  property p_under_pulse;
    underrun |-> (r.st == st_under && serial_data_oe && !serial_data_pin);
  endproperty
  a_under_pulse: assert property (p_under_pulse) else $error("underrun without a held low line");

  property p_take_place;
    sample_take |-> (r.st == st_run && r.half == 6'h00 && !r.sub);
  endproperty
  a_take_place: assert property (p_take_place) else $error("sample taken off a frame start");

endmodule : bat_framer

// *** dv/bat_rx_model.sv ***
/*
  Receiver model for the framer line: collects the 64 line states of each
  subframe and decodes preamble and biphase cells.
  Assumes the framer's pin, output enable and block pulse on clk_sys.
*/
`timescale 1ns/10ps

module bat_rx_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // line from the framer
  input wire logic serial_data_pin,
  input wire logic serial_data_oe,
  input wire logic block_start,
  // decoded subframe
  output logic sf_done,
  output logic [7:0] sf_pre,
  output logic [31:4] sf_cells,
  output logic sf_err,
  output logic sf_bs
);
  logic busy;
  logic [5:0] cnt;
  logic [63:0] sh;
  logic prev;

  // hunt for a rising line, then take exactly 64 states
  always_ff @(posedge clk_sys) begin
    sf_done <= 1'b0;
    if (srst) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      sf_bs <= 1'b0;
    end else if (!busy) begin
      // preamble always opens high after a low line
      if (serial_data_oe && serial_data_pin) begin
        busy <= 1'b1;
        cnt <= 6'h01;
        sh <= 64'h1;
        sf_bs <= block_start;
      end
    end else begin
      sh <= {sh[62:0], serial_data_pin};
      sf_bs <= sf_bs | block_start;
      cnt <= cnt + 6'h01;
      if (cnt == 6'h3f) begin
        busy <= 1'b0;
        sf_done <= 1'b1;
      end
    end
  end

  // raw preamble, then cells that must flip at their start
  always_comb begin
    sf_pre = sh[63:56];
    sf_err = sh[0]; // a high end would break the next preamble
    prev = sh[56];
    for (int n = 4; n < 32; n++) begin
      sf_cells[n] = sh[63-2*n] ^ sh[62-2*n];
      if (sh[63-2*n] == prev) sf_err = 1'b1;
      prev = sh[62-2*n];
    end
  end
endmodule : bat_rx_model

// *** dv/bat_framer_tb.sv ***
/*
  Self-checking bench of the framer: random stereo and mono frames, an
  underrun, a disable, and a full channel-status block with wrap.
  Assumes bat_regs.svh on the include path and the receiver model.
*/
`timescale 1ns/10ps
`include "bat_regs.svh"

module bat_framer_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic mode = 1'b0, w24 = 1'b1, mono = 1'b0, dup = 1'b0, sv = 1'b0;
  logic [4:0] src = 5'h18;
  logic [23:0] ls = 24'h0, rs = 24'h0;
  logic [3:0] la = 4'h0, ra = 4'h0;
  logic [5:0] side = 6'h00; // {lv, rv, lu, ru, lc, rc}
  logic take, pin, oe, under, bstart, sf_done, sf_err, sf_bs;
  logic [7:0] sf_pre;
  logic [31:4] sf_cells;
  logic [37:0] expq[$];
  logic [37:0] got;
  int miscompares = 0, n_tests = 0, fcnt = 0, i;

  always #25 clk_sys = ~clk_sys;

  bat_framer i_bat_framer (.clk_sys(clk_sys), .srst(srst), .digital_audio_transmit_mode(mode),
    .word_24(w24), .src_bits(src), .mono(mono), .mono_dup(dup), .sample_valid(sv),
    .left_sample(ls), .right_sample(rs), .left_aux(la), .right_aux(ra),
    .left_validity(side[5]), .right_validity(side[4]), .left_user(side[3]), .right_user(side[2]),
    .left_cs(side[1]), .right_cs(side[0]), .sample_take(take), .serial_data_pin(pin),
    .serial_data_oe(oe), .underrun(under), .block_start(bstart));

  bat_rx_model i_bat_rx_model (.clk_sys(clk_sys), .srst(srst), .serial_data_pin(pin),
    .serial_data_oe(oe), .block_start(bstart), .sf_done(sf_done), .sf_pre(sf_pre),
    .sf_cells(sf_cells), .sf_err(sf_err), .sf_bs(sf_bs));

  // decoded subframe in the same layout as the notes
  assign got = {sf_bs, sf_err, sf_pre, sf_cells};

  task automatic miss(string m);
    $display("[FAIL] %0t %s", $time, m);
    miscompares++;
  endtask : miss

  task automatic check_sf(logic [37:0] e, logic [37:0] g);
    n_tests++;
    if (g !== e) miss($sformatf("subframe got %h exp %h", g, e));
  endtask : check_sf

  task automatic check_flag(logic e, logic g, string m);
    n_tests++;
    if (g !== e) miss(m);
  endtask : check_flag

  // expected cells 4..31; narrow sources lose their low bits
  function automatic logic [31:4] cells_of(logic [23:0] s, logic [3:0] a, logic v, logic u, logic c);
    logic [31:0] w;
    int n;
    n = (src == 5'h00 || src > 5'h18) ? 24 : int'(src);
    s = s & ~((24'h1 << (24 - n)) - 24'h1);
    w = {1'b0, c, u, v, w24 ? s : {s[23:4], a}, 4'h0};
    w[31] = ^w[30:4];
    return w[31:4];
  endfunction : cells_of

  function automatic logic [37:0] ent(logic [7:0] p, logic [31:4] c);
    return {p == `BAT_PRE_BLOCK, 1'b0, p, c};
  endfunction : ent

  // one frame: random format and data, notes both subframes, waits for the take
  task automatic frame;
    logic [7:0] p;
    int k;
    w24 = 1'($urandom);
    src = 5'($urandom);
    mono = ($urandom % 4) == 0;
    dup = 1'($urandom);
    ls = 24'($urandom);
    rs = 24'($urandom);
    la = 4'($urandom);
    side = 6'($urandom);
    // mono keeps right side bits equal to left, so dup reads alike either way
    if (mono) side = {side[5], side[5], side[3], side[3], side[1], side[1]};
    ra = mono ? la : 4'($urandom);
    p = (fcnt % `BAT_FRAMES_PER_BLOCK == 0) ? `BAT_PRE_BLOCK : `BAT_PRE_FIRST;
    expq.push_back(ent(p, cells_of(ls, la, side[5], side[3], side[1])));
    expq.push_back(ent(`BAT_PRE_SECOND, cells_of(mono ? (dup ? ls : 24'h0) : rs, (mono && !dup) ? 4'h0 : ra,
      (mono && !dup) | side[4], side[2], side[0])));
    sv = 1'b1;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (take !== 1'b1 && k < 300);
    if (k >= 300) miss("no sample take");
    fcnt++;
  endtask : frame

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // oldest note against each decoded subframe
  always @(negedge clk_sys) begin
    if (sf_done === 1'b1) begin
      if (expq.size() == 0) begin
        miss("unexpected subframe");
      end else begin
        check_sf(expq.pop_front(), got);
      end
    end
  end

  // watchdog sized for about 312 frames of 128 clocks
  initial begin
    repeat (40000) @(posedge clk_sys);
    miss("timeout");
    close_out();
  end

  initial begin
    void'($urandom(32'h7913d253));
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    mode = 1'b1;
    repeat (3) frame();
    // starve the source: frame skipped, line held low, counter held
    sv = 1'b0;
    i = 0;
    while (under !== 1'b1 && i < 300) begin
      @(negedge clk_sys);
      i++;
    end
    check_flag(1'b1, under, "no underrun pulse");
    check_flag(1'b0, pin, "line not low in underrun");
    repeat (2) frame();
    // disable at the boundary drops the driver and clears the counter
    mode = 1'b0;
    sv = 1'b0;
    repeat (160) @(negedge clk_sys);
    check_flag(1'b0, oe, "still driving after disable");
    mode = 1'b1;
    fcnt = 0;
    repeat (194) frame();
    sv = 1'b0;
    repeat (300) @(negedge clk_sys);
    check_flag(1'b1, expq.size() == 0, "subframes missing");
    close_out();
  end
endmodule : bat_framer_tb
